// ---- design/jtag_bridge_params.svh ----
// Constants for the scan-chain register bridge.
// Assumes inclusion by bare name from design files.
`ifndef JTAG_BRIDGE_PARAMS_SVH
`define JTAG_BRIDGE_PARAMS_SVH

// Instruction codes
`define IR_LEN 8
`define IR_DATA_PACKET 8'h25
`define IR_ACCESS_CTRL 8'h26
`define IR_BYPASS 8'hff
`define IR_CAPTURE 8'h01

// Chain lengths
`define CTRL_LEN 12
`define PKT_LEN 72

// Control chain fields
`define CTRL_MUX_WR 6
`define CTRL_IN_HI 5
`define CTRL_IN_LO 4
`define CTRL_GPA_HI 3
`define CTRL_GPA_LO 2
`define CTRL_GPB_HI 1
`define CTRL_GPB_LO 0
`define SEL_VALUE 2'b00
`define SEL_STATUS 2'b01
`define SEL_WRITE 2'b10

// Packet field positions
`define BYTE_HI(n) ((n) * 8 - 1)
`define BYTE_LO(n) (((n) - 1) * 8)
`define CMP_TOP 71
`define RESULT_HI 43
`define RESULT_LO 32
`define MUX_HI 31
`define MUX_LO 27
`define INV_HI 22
`define INV_LO 20
`define GPA_HI 15
`define GPA_LO 8
`define GPB_HI 7
`define GPB_LO 2

// Reset values
`define MUX_RESET 5'h00
`define GPA_RESET 8'h04
`define GPB_RESET 6'h00
`define INV_RESET 3'h0
`define CTRL_RESET 12'h000

// Equivalent two-wire bus addresses of the packet bytes
`define ADDR_MON_A 8'h00
`define ADDR_MON_B 8'h01
`define ADDR_MON_C 8'h02
`define ADDR_LVL_A 8'h03
`define ADDR_LVL_B 8'h04
`define ADDR_PIN_RPT 8'h06
`define ADDR_RES_LO 8'h07
`define ADDR_RES_HI 8'h08
`define ADDR_SRC_SEL 8'h09
`define ADDR_DRV_A 8'h0e
`define ADDR_DRV_B 8'h0f
`define ADDR_IN_OVR 8'h11

`endif

// ---- design/jtag_bridge_pkg.sv ----
// Types shared by the scan-chain register bridge.
// Assumes nothing of its surroundings.
package jtag_bridge_pkg;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_t;

    typedef struct packed {
        logic [9:0] cmp_a;
        logic [9:0] cmp_b;
        logic [11:0] result;
        logic [4:0] mux;
        logic [2:0] inv;
        logic [2:0] instat;
        logic [7:0] gpa;
        logic [5:0] gpb;
        logic [13:0] lvl;
    } snap_t;

    typedef struct packed {
        logic mux_we;
        logic [4:0] mux;
        logic inv_we;
        logic [2:0] inv;
        logic gpa_we;
        logic [7:0] gpa;
        logic gpb_we;
        logic [5:0] gpb;
    } wr_t;

endpackage

// ---- design/tap_ctrl.sv ----
// Test access port state machine.
// Assumes TMS is stable around the rising edge of the test clock.
`timescale 1ns/1ps
module tap_ctrl
(
    input wire logic tck_i,
    input wire logic trst_n_i,
    input wire logic tms_i,
    output jtag_bridge_pkg::tap_state_t state_o
);
    import jtag_bridge_pkg::*;

    tap_state_t st_q;
    tap_state_t st_d;

    always_comb
    begin
        case (st_q)
            TAP_RESET: st_d = tms_i ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: st_d = tms_i ? SEL_DR : TAP_IDLE;
            SEL_DR: st_d = tms_i ? SEL_IR : CAP_DR;
            CAP_DR: st_d = tms_i ? EX1_DR : SH_DR;
            SH_DR: st_d = tms_i ? EX1_DR : SH_DR;
            EX1_DR: st_d = tms_i ? UPD_DR : PA_DR;
            PA_DR: st_d = tms_i ? EX2_DR : PA_DR;
            EX2_DR: st_d = tms_i ? UPD_DR : SH_DR;
            UPD_DR: st_d = tms_i ? SEL_DR : TAP_IDLE;
            SEL_IR: st_d = tms_i ? TAP_RESET : CAP_IR;
            CAP_IR: st_d = tms_i ? EX1_IR : SH_IR;
            SH_IR: st_d = tms_i ? EX1_IR : SH_IR;
            EX1_IR: st_d = tms_i ? UPD_IR : PA_IR;
            PA_IR: st_d = tms_i ? EX2_IR : PA_IR;
            EX2_IR: st_d = tms_i ? UPD_IR : SH_IR;
            UPD_IR: st_d = tms_i ? SEL_DR : TAP_IDLE;
            default: st_d = TAP_RESET;
        endcase
    end

    // Test reset forces the reset state at once
    always_ff @(posedge tck_i or negedge trst_n_i)
    begin
        if (!trst_n_i)
            st_q <= TAP_RESET;
        else
            st_q <= st_d;
    end

    assign state_o = st_q;

endmodule // tap_ctrl

// ---- design/word_xfer.sv ----
// Two-phase toggle handshake carrying one word between clock domains.
// Assumes each side's reset is synchronous to its own clock.
`timescale 1ns/1ps
module word_xfer
#(
    parameter int W = 8
)
(
    input wire logic s_clk_i,
    input wire logic s_rst_i,
    input wire logic s_valid_i,
    input wire logic [W-1:0] s_data_i,
    output logic s_busy_o,
    input wire logic d_clk_i,
    input wire logic d_rst_i,
    output logic d_valid_o,
    output logic [W-1:0] d_data_o
);
    logic [W-1:0] hold_q;
    logic req_q, ack_meta_q, ack_sync_q;
    logic req_meta_q, req_sync_q, ack_q, d_valid_q;
    logic [W-1:0] d_data_q;

    // Source side: hold word stable until acknowledged
    always_ff @(posedge s_clk_i)
    begin
        if (s_rst_i)
        begin
            hold_q <= '0;
            req_q <= 1'b0;
        end
        else if (s_valid_i && !s_busy_o)
        begin
            hold_q <= s_data_i;
            req_q <= ~req_q;
        end
    end

    always_ff @(posedge s_clk_i)
    begin
        ack_meta_q <= ack_q;
        ack_sync_q <= ack_meta_q;
    end

    assign s_busy_o = req_q ^ ack_sync_q;

    // Destination side
    always_ff @(posedge d_clk_i)
    begin
        req_meta_q <= req_q;
        req_sync_q <= req_meta_q;
    end

    always_ff @(posedge d_clk_i)
    begin
        if (d_rst_i)
        begin
            ack_q <= 1'b0;
            d_valid_q <= 1'b0;
            d_data_q <= '0;
        end
        else
        begin
            d_valid_q <= req_sync_q ^ ack_q;
            ack_q <= req_sync_q;
            if (req_sync_q ^ ack_q)
                d_data_q <= hold_q;
        end
    end

    assign d_valid_o = d_valid_q;
    assign d_data_o = d_data_q;

endmodule // word_xfer

// ---- design/jtag_reg_bridge.sv ----
// Scan-chain bridge giving a test host access to the device register set.
// Assumes tck_i is unrelated to clk_i and may stop between scans.
//
// Summary of operation
// - Instruction 0x25 selects the 72-bit packet, 0x26 the 12-bit control chain.
// - Packet is 72 bits, nine bytes, each byte one register group.
// - Packet read returns every register value, except in bytes 3..1 while their control pair is 01.
// - Chains capture, shift and update in the standard port states.
// - Byte 9 leaves last; final bit out is bit 71, monitor one first flag.
// - Bits 71..52 are comparator pairs; 51..48 read one; bytes 9..7 not writable.
// - Result bits 0..3 at 43..40, 4..11 at 39..32; 47..44 read one.
// - Control bit 6 set lets packet write load selection and attenuate from byte 4.
// - Byte 4 reads the current selection whatever control bit 6 holds.
// - Control bits 5:4 equal 10 write byte 3 into input override.
// - Byte 3 reads override at 00, input pin report at 01.
// - Pairs 3:2 and 1:0 equal 10 write drive registers from bytes 2, 1.
// - Bytes 2, 1 read drive registers at 00, pin levels at 01.
// - Bytes 9..4 each stand for one two-wire register address, bytes 3..1 for two.
// - Non-functional packet bits always read as ones.
// - After reset the selection byte holds zero select and attenuate bits.
`timescale 1ns/1ps
`include "jtag_bridge_params.svh"
module jtag_reg_bridge
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic tck_i,
    input wire logic trst_n_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic [9:0] monitor_comparator_first_i,
    input wire logic [9:0] monitor_comparator_second_i,
    input wire logic [11:0] conv_result_i,
    input wire logic [2:0] logic_pin_i,
    input wire logic [13:0] out_pin_level_i,
    output logic [3:0] converter_select_bit_o,
    output logic attenuate_bit_o,
    output logic [2:0] logic_input_override_o,
    output logic [7:0] general_drive_a_o,
    output logic [5:0] general_drive_b_o
);
    import jtag_bridge_pkg::*;

    // Byte 3/2/1 read choice: status at 01, register otherwise
    function automatic logic [7:0] pick_byte(input logic [1:0] sel, input logic [7:0] value,
                                             input logic [7:0] status);
        pick_byte = (sel == `SEL_STATUS) ? status : value;
    endfunction

    //************************************************************
    // System clock side
    //************************************************************
    logic [36:0] pin_meta_q;
    logic [36:0] pin_sync_q;
    logic [4:0] mux_q;
    logic [2:0] inv_q;
    logic [7:0] gpa_q;
    logic [5:0] gpb_q;
    logic snap_busy;
    logic wr_valid;
    wr_t wr_word;
    logic [$bits(wr_t)-1:0] wr_bits;
    snap_t snap_src;

    always_ff @(posedge clk_i)
    begin
        pin_meta_q <= {monitor_comparator_first_i, monitor_comparator_second_i,
                       logic_pin_i, out_pin_level_i};
        pin_sync_q <= pin_meta_q;
    end

    assign wr_word = wr_t'(wr_bits);

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            mux_q <= `MUX_RESET;
        else if (wr_valid && wr_word.mux_we)
            mux_q <= wr_word.mux;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            inv_q <= `INV_RESET;
        else if (wr_valid && wr_word.inv_we)
            inv_q <= wr_word.inv;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            gpa_q <= `GPA_RESET;
            gpb_q <= `GPB_RESET;
        end
        else if (wr_valid)
        begin
            if (wr_word.gpa_we)
                gpa_q <= wr_word.gpa;
            if (wr_word.gpb_we)
                gpb_q <= wr_word.gpb;
        end
    end

    assign converter_select_bit_o = {<<{mux_q[4:1]}};
    assign attenuate_bit_o = mux_q[0];
    assign logic_input_override_o = inv_q;
    assign general_drive_a_o = gpa_q;
    assign general_drive_b_o = gpb_q;

    // Snapshot of everything readable, refreshed continuously
    always_comb
    begin
        snap_src.cmp_a = pin_sync_q[36:27];
        snap_src.cmp_b = pin_sync_q[26:17];
        snap_src.result = conv_result_i;
        snap_src.mux = mux_q;
        snap_src.inv = inv_q;
        snap_src.instat = {<<{pin_sync_q[16:14]}};
        snap_src.gpa = gpa_q;
        snap_src.gpb = gpb_q;
        snap_src.lvl = pin_sync_q[13:0];
    end

    //************************************************************
    // Test clock side
    //************************************************************
    tap_state_t tap_state;
    logic tlr;
    logic [`IR_LEN-1:0] ir_sh_q;
    logic [`IR_LEN-1:0] ir_q;
    logic [`CTRL_LEN-1:0] ctrl_sh_q;
    logic [`CTRL_LEN-1:0] ctrl_q;
    logic [`PKT_LEN-1:0] pkt_sh_q;
    logic [`PKT_LEN-1:0] rd_pkt;
    logic byp_q;
    logic tdo_q;
    logic tdo_oe_q;
    logic data_sel;
    logic ctrl_sel;
    logic pkt_update;
    logic [$bits(snap_t)-1:0] snap_bits;
    snap_t snap;
    wr_t wr_src;
    logic [7:0] lvl_a_rev;
    logic [5:0] lvl_b_rev;

    tap_ctrl u_tap
    (
        .tck_i(tck_i),
        .trst_n_i(trst_n_i),
        .tms_i(tms_i),
        .state_o(tap_state)
    );

    assign tlr = (tap_state == TAP_RESET);
    assign data_sel = (ir_q == `IR_DATA_PACKET);
    assign ctrl_sel = (ir_q == `IR_ACCESS_CTRL);
    assign snap = snap_t'(snap_bits);
    assign lvl_a_rev = {<<{snap.lvl[7:0]}};
    assign lvl_b_rev = {<<{snap.lvl[13:8]}};

    always_ff @(posedge tck_i)
    begin
        if (tap_state == CAP_IR)
            ir_sh_q <= `IR_CAPTURE;
        else if (tap_state == SH_IR)
            ir_sh_q <= {tdi_i, ir_sh_q[`IR_LEN-1:1]};
    end

    always_ff @(posedge tck_i)
    begin
        if (tlr)
            ir_q <= `IR_BYPASS;
        else if (tap_state == UPD_IR)
            ir_q <= ir_sh_q;
    end

    always_ff @(posedge tck_i)
    begin
        if (tap_state == CAP_DR)
            byp_q <= 1'b0;
        else if (tap_state == SH_DR)
            byp_q <= tdi_i;
    end

    // Control chain
    always_ff @(posedge tck_i)
    begin
        if (ctrl_sel && tap_state == CAP_DR)
            ctrl_sh_q <= ctrl_q;
        else if (ctrl_sel && tap_state == SH_DR)
            ctrl_sh_q <= {tdi_i, ctrl_sh_q[`CTRL_LEN-1:1]};
    end

    always_ff @(posedge tck_i)
    begin
        if (tlr)
            ctrl_q <= `CTRL_RESET;
        else if (ctrl_sel && tap_state == UPD_DR)
            ctrl_q <= ctrl_sh_q;
    end

    // Read packet: bytes 9..1 carry two-wire addresses 0x00..0x11
    always_comb
    begin
        rd_pkt = '1;
        for (int i = 0; i < 10; i++)
        begin
            rd_pkt[`CMP_TOP - 2 * i] = snap.cmp_a[i];
            rd_pkt[`CMP_TOP - 1 - 2 * i] = snap.cmp_b[i];
        end
        rd_pkt[`RESULT_HI:`RESULT_LO] = {<<{snap.result}};
        rd_pkt[`MUX_HI:`MUX_LO] = snap.mux;
        rd_pkt[`BYTE_HI(3):`BYTE_LO(3)] = pick_byte(ctrl_q[`CTRL_IN_HI:`CTRL_IN_LO],
            {1'b1, snap.inv, 4'hf}, {1'b1, snap.instat, 4'hf});
        rd_pkt[`BYTE_HI(2):`BYTE_LO(2)] = pick_byte(ctrl_q[`CTRL_GPA_HI:`CTRL_GPA_LO],
            snap.gpa, lvl_a_rev);
        rd_pkt[`BYTE_HI(1):`BYTE_LO(1)] = pick_byte(ctrl_q[`CTRL_GPB_HI:`CTRL_GPB_LO],
            {snap.gpb, 2'b11}, {lvl_b_rev, 2'b11});
    end

    // Data packet: LSB out first, bit 71 out last
    always_ff @(posedge tck_i)
    begin
        if (data_sel && tap_state == CAP_DR)
            pkt_sh_q <= rd_pkt;
        else if (data_sel && tap_state == SH_DR)
            pkt_sh_q <= {tdi_i, pkt_sh_q[`PKT_LEN-1:1]};
    end

    // Write word; bytes 9..5 are never forwarded
    assign pkt_update = data_sel && (tap_state == UPD_DR);
    always_comb
    begin
        wr_src.mux_we = ctrl_q[`CTRL_MUX_WR];
        wr_src.mux = pkt_sh_q[`MUX_HI:`MUX_LO];
        wr_src.inv_we = (ctrl_q[`CTRL_IN_HI:`CTRL_IN_LO] == `SEL_WRITE);
        wr_src.inv = pkt_sh_q[`INV_HI:`INV_LO];
        wr_src.gpa_we = (ctrl_q[`CTRL_GPA_HI:`CTRL_GPA_LO] == `SEL_WRITE);
        wr_src.gpa = pkt_sh_q[`GPA_HI:`GPA_LO];
        wr_src.gpb_we = (ctrl_q[`CTRL_GPB_HI:`CTRL_GPB_LO] == `SEL_WRITE);
        wr_src.gpb = pkt_sh_q[`GPB_HI:`GPB_LO];
    end

    // Serial output changes on the falling edge
    always_ff @(negedge tck_i)
    begin
        if (tlr)
        begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end
        else
        begin
            tdo_oe_q <= (tap_state == SH_IR) || (tap_state == SH_DR);
            if (tap_state == SH_IR)
                tdo_q <= ir_sh_q[0];
            else if (data_sel)
                tdo_q <= pkt_sh_q[0];
            else if (ctrl_sel)
                tdo_q <= ctrl_sh_q[0];
            else
                tdo_q <= byp_q;
        end
    end

    assign tdo_o = tdo_q;
    assign tdo_oe_o = tdo_oe_q;

    //************************************************************
    // Domain crossings
    //************************************************************
    word_xfer #(.W($bits(snap_t))) u_rd_xfer
    (
        .s_clk_i(clk_i),
        .s_rst_i(srst_i),
        .s_valid_i(1'b1),
        .s_data_i(snap_src),
        .s_busy_o(snap_busy),
        .d_clk_i(tck_i),
        .d_rst_i(tlr),
        .d_valid_o(),
        .d_data_o(snap_bits)
    );

    word_xfer #(.W($bits(wr_t))) u_wr_xfer
    (
        .s_clk_i(tck_i),
        .s_rst_i(tlr),
        .s_valid_i(pkt_update),
        .s_data_i(wr_src),
        .s_busy_o(),
        .d_clk_i(clk_i),
        .d_rst_i(srst_i),
        .d_valid_o(wr_valid),
        .d_data_o(wr_bits)
    );

    //************************************************************
    // Assertions
    //************************************************************
    a_ir_selects_data:
    assert property (@(posedge tck_i) disable iff (!trst_n_i)
        (tap_state == UPD_IR && ir_sh_q == `IR_DATA_PACKET) |=> data_sel && !ctrl_sel)
    else $error("data instruction not decoded");

    a_ir_selects_ctrl:
    assert property (@(posedge tck_i) disable iff (!trst_n_i)
        (tap_state == UPD_IR && ir_sh_q == `IR_ACCESS_CTRL) |=> ctrl_sel && !data_sel)
    else $error("control instruction not decoded");

    a_ctrl_persists:
    assert property (@(posedge tck_i) disable iff (!trst_n_i || tlr)
        !(ctrl_sel && tap_state == UPD_DR) |=> tlr || $stable(ctrl_q))
    else $error("control value changed without update");

    a_fill_ones:
    assert property (@(posedge tck_i) disable iff (!trst_n_i || tlr)
        (data_sel && tap_state == CAP_DR) |=>
        (pkt_sh_q[51:44] == 8'hff) && (pkt_sh_q[26:24] == 3'h7) && pkt_sh_q[23])
    else $error("non-functional packet bits not one");

    a_first_flag_last:
    assert property (@(posedge tck_i) disable iff (!trst_n_i || tlr)
        (data_sel && tap_state == CAP_DR) |=> pkt_sh_q[`CMP_TOP] == $past(snap.cmp_a[0]))
    else $error("bit 71 is not monitor one first flag");

    a_oe_in_shift:
    assert property (@(posedge tck_i) disable iff (!trst_n_i || tlr)
        tdo_oe_q == (tap_state == SH_IR || tap_state == SH_DR))
    else $error("output enable does not follow shift states");

    a_byte3_status:
    assert property (@(posedge tck_i) disable iff (!trst_n_i || tlr)
        (data_sel && tap_state == CAP_DR && ctrl_q[5:4] == `SEL_STATUS) |=>
        pkt_sh_q[`INV_HI:`INV_LO] == $past(snap.instat))
    else $error("byte 3 does not report input pins");

    a_mux_write:
    assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_valid && wr_word.mux_we) |=> mux_q == $past(wr_word.mux))
    else $error("selection byte not written");

    a_mux_ignored:
    assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_valid && !wr_word.mux_we) |=> $stable(mux_q))
    else $error("selection byte written while disabled");

    a_drive_write:
    assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_valid && wr_word.gpa_we && !wr_word.gpb_we) |=>
        gpa_q == $past(wr_word.gpa) && $stable(gpb_q))
    else $error("drive register write wrong");

    a_override_write:
    assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_valid && wr_word.inv_we) |=> inv_q == $past(wr_word.inv))
    else $error("input override not written");

    a_reset_values:
    assert property (@(posedge clk_i)
        srst_i |=> mux_q == `MUX_RESET && gpa_q == `GPA_RESET && inv_q == `INV_RESET &&
        gpb_q == `GPB_RESET)
    else $error("reset values wrong");

    c_mux_write: cover property (@(posedge clk_i) disable iff (srst_i)
        wr_valid && wr_word.mux_we);
    c_status_read: cover property (@(posedge tck_i) disable iff (!trst_n_i)
        data_sel && tap_state == CAP_DR && ctrl_q[1:0] == `SEL_STATUS);
    c_ctrl_update: cover property (@(posedge tck_i) disable iff (!trst_n_i)
        ctrl_sel && tap_state == UPD_DR);
    c_snap_refresh: cover property (@(posedge clk_i) disable iff (srst_i) !snap_busy);

endmodule // jtag_reg_bridge

// ---- dv/jtag_host_model.sv ----
// Behavioural test host driving the scan port of the register bridge.
// Assumes the bridge samples TMS/TDI on the rising test clock edge.
`timescale 1ns/1ps
module jtag_host_model
(
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_n_o,
    input wire logic tdo_i
);
    logic dummy;
    // Test clock stands still low outside frames
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        trst_n_o = 1'b0;
    end
    // ****************************************
    // One test clock period of 64 ns
    // ****************************************
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #32;
        tck_o = 1'b1;
        tdo = tdo_i;
        #32;
        tck_o = 1'b0;
    endtask
    task automatic tap_reset();
        trst_n_o = 1'b0;
        #100;
        trst_n_o = 1'b1;
        step(1'b1, tdi_o, dummy);
        step(1'b1, tdi_o, dummy);
        step(1'b0, tdi_o, dummy);
    endtask
    task automatic idle(input int n);
        #1.3;
        repeat (n) step(1'b0, tdi_o, dummy);
    endtask
    // Idle to idle scan, LSB first; tdo taken at each shifting edge
    task automatic scan(input bit ir, input int n, input logic [71:0] din,
                        output logic [71:0] dout);
        dout = '0;
        #1.3;
        step(1'b1, tdi_o, dummy);
        if (ir)
            step(1'b1, tdi_o, dummy);
        step(1'b0, tdi_o, dummy);
        step(1'b0, tdi_o, dummy);
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], dout[i]);
        step(1'b1, tdi_o, dummy);
        step(1'b0, tdi_o, dummy);
        tdi_o = ~tdi_o;
    endtask
endmodule // jtag_host_model

// ---- dv/jtag_reg_bridge_tb_top.sv ----
// Self-checking bench for the scan-chain register bridge.
// Assumes jtag_host_model and the design files are compiled first.
`timescale 1ns/1ps
`include "jtag_bridge_params.svh"
module jtag_reg_bridge_tb_top;
    import jtag_bridge_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe, att;
    logic [9:0] cmp_a = 10'h2a5;
    logic [9:0] cmp_b = 10'h13c;
    logic [11:0] res = 12'hc3a;
    logic [2:0] pin = 3'h3;
    logic [13:0] lvl = 14'h2d61;
    logic [3:0] sel;
    logic [2:0] inv;
    logic [7:0] gpa;
    logic [5:0] gpb;
    logic [21:0] mdl = {4'h0, 1'b0, 3'h0, 8'h04, 6'h00};
    logic [71:0] got;
    int err_total = 0;
    int comparisons = 0;
    always #2 clk_i = ~clk_i;
    jtag_reg_bridge jtag_reg_bridge_i (.clk_i(clk_i), .srst_i(srst_i), .tck_i(tck),
        .trst_n_i(trst_n), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .monitor_comparator_first_i(cmp_a), .monitor_comparator_second_i(cmp_b),
        .conv_result_i(res), .logic_pin_i(pin), .out_pin_level_i(lvl),
        .converter_select_bit_o(sel), .attenuate_bit_o(att), .logic_input_override_o(inv),
        .general_drive_a_o(gpa), .general_drive_b_o(gpb));
    jtag_host_model jtag_host_model_i (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .trst_n_o(trst_n), .tdo_i(tdo));
    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic chk_outs();
        check({50'h0, sel, att, inv, gpa, gpb}, {50'h0, mdl});
    endtask
    function automatic logic [71:0] pkt_exp(input logic [11:0] c);
        logic [71:0] p;
        p = '1;
        for (int k = 0; k < 10; k++)
        begin
            p[71 - 2 * k] = cmp_a[k];
            p[70 - 2 * k] = cmp_b[k];
        end
        for (int i = 0; i < 12; i++) p[43 - i] = res[i];
        for (int i = 0; i < 4; i++) p[31 - i] = mdl[18 + i];
        p[27] = mdl[17];
        p[22:20] = (c[5:4] == 2'b01) ? {pin[0], pin[1], pin[2]} : mdl[16:14];
        p[15:8] = mdl[13:6];
        p[7:2] = mdl[5:0];
        if (c[3:2] == 2'b01)
            for (int i = 0; i < 8; i++) p[15 - i] = lvl[i];
        if (c[1:0] == 2'b01)
            for (int i = 0; i < 6; i++) p[7 - i] = lvl[8 + i];
        return p;
    endfunction
    task automatic scan_ctrl(input logic [11:0] c);
        jtag_host_model_i.scan(1'b1, 8, {64'h0, `IR_ACCESS_CTRL}, got);
        jtag_host_model_i.scan(1'b0, 12, {60'h0, c}, got);
    endtask
    task automatic pkt(input logic [71:0] d);
        jtag_host_model_i.scan(1'b1, 8, {64'h0, `IR_DATA_PACKET}, got);
        jtag_host_model_i.scan(1'b0, 72, d, got);
        jtag_host_model_i.idle(12);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk_outs();
        scan_ctrl(12'h000);
        pkt(72'h0);
        check(got, pkt_exp(12'h000));
        check({71'h0, tdo_oe}, 72'h0);
        $display("test reset done");
    endtask
    task automatic t_write();
        scan_ctrl(12'h06a);
        pkt(72'h0000000000b850a5c8);
        mdl = {4'b1101, 1'b1, 3'b101, 8'ha5, 6'b110010};
        chk_outs();
        scan_ctrl(12'h000);
        pkt(72'hffffffffffffffffff);
        check(got, pkt_exp(12'h000));
        chk_outs();
        $display("test write done");
    endtask
    task automatic t_status();
        @(negedge clk_i);
        cmp_a = 10'h1c6;
        cmp_b = 10'h259;
        res = 12'h5e3;
        pin = 3'h6;
        lvl = 14'h1a9e;
        jtag_host_model_i.idle(12);
        scan_ctrl(12'h015);
        pkt(72'hffffffffffffffffff);
        check(got, pkt_exp(12'h015));
        chk_outs();
        $display("test status done");
    endtask
    task automatic t_partial();
        scan_ctrl(12'h040);
        pkt(72'h000000000050ff0000);
        jtag_host_model_i.idle(1000);
        mdl[21:17] = 5'b10100;
        chk_outs();
        $display("test partial done");
    endtask
    task automatic t_trst();
        scan_ctrl(12'h06a);
        jtag_host_model_i.tap_reset();
        jtag_host_model_i.idle(12);
        pkt(72'h0000000000ffffffff);
        chk_outs();
        jtag_host_model_i.scan(1'b1, 8, {64'h0, `IR_BYPASS}, got);
        jtag_host_model_i.scan(1'b0, 4, 72'hb, got);
        check(got, 72'h6);
        $display("test trst done");
    endtask
    // ****************************************
    // Run control
    // ****************************************
    task automatic tally_and_finish();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        srst_i = 1'b0;
        jtag_host_model_i.tap_reset();
        jtag_host_model_i.idle(12);
        t_reset();
        t_write();
        t_status();
        t_partial();
        t_trst();
        tally_and_finish();
    end
    initial
    begin
        #300000;
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule // jtag_reg_bridge_tb_top
